// >>> gcrb_pkg.sv
// Purpose: constants and types of the generic clock register bank
// Assumes: apb with 32-bit data; printed offsets are byte addresses
// Notes:   word 0x0 packs control, status and clock route control
package gcrb_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL_WORD = 12'h000;
	localparam logic [11:0] ADDR_GEN_SETUP = 12'h004;
	localparam logic [11:0] ADDR_GEN_RATIO = 12'h008;
	// fields in word 0 (control byte 0, status byte 1, route bytes 2-3)
	localparam int SOFT_RESET_POS = 0;
	localparam int SYNC_PEND_POS  = 15;
	localparam int IDX_LO         = 16;
	localparam int SEL_LO         = 24;
	localparam int GATE_POS       = 30;
	localparam int FREEZE_POS     = 31;
	// generator setup fields
	localparam logic [31:0] SETUP_MASK = 32'h003f1f0f;
	localparam logic [31:0] RATIO_MASK = 32'h00ffff0f;
	localparam logic [31:0] SETUP_RST  = 32'h00000000;
	localparam logic [31:0] RATIO_RST  = 32'h00000000;
	localparam logic [3:0]  GEN_MAX    = 4'h8;
	// synchroniser depth into generator domains, in bus cycles
	localparam logic [2:0]  SYNC_CYCLES = 3'h4;

	typedef enum logic [1:0] {
		SY_IDLE  = 2'b00,
		SY_BUSY  = 2'b01,
		SY_DONE  = 2'b11
	} gcrb_sync_type;
endpackage : gcrb_pkg

// >>> gcrb_sync_if.sv
`timescale 1ns/1ns
// Purpose: request/done pair between bank and sync timer
// Assumes: one bus clock
// Notes:   start is a one-cycle pulse
interface gcrb_sync_if;
	logic start;
	logic busy;
	logic done;
	modport bank  (output start, input busy, input done);
	modport timer (input start, output busy, output done);
endinterface : gcrb_sync_if

// >>> gcrb_sync_timer.sv
`timescale 1ns/1ns
// Purpose: models the crossing delay into the generator domains
// Assumes: start only while idle
// Notes:   done pulses one cycle as busy falls
module gcrb_sync_timer
	import gcrb_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	gcrb_sync_if.timer sy
);
	gcrb_sync_type state_ff;
	gcrb_sync_type nxt_state;
	logic [2:0]    cnt_ff;
	logic [2:0]    nxt_cnt;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			SY_IDLE: begin
				if (sy.start) begin
					nxt_state = SY_BUSY;
					nxt_cnt   = SYNC_CYCLES - 3'h1;
				end
			end
			SY_BUSY: begin
				if (cnt_ff == 3'h0)
					nxt_state = SY_DONE;
				else
					nxt_cnt = cnt_ff - 3'h1;
			end
			SY_DONE: nxt_state = SY_IDLE;
			default: nxt_state = SY_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= SY_IDLE;
			cnt_ff   <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	assign sy.busy = (state_ff != SY_IDLE);
	assign sy.done = (state_ff == SY_DONE);
endmodule : gcrb_sync_timer

// >>> gcrb_route_bank.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
// Purpose: generic clock register bank behind apb
// Assumes: i_prot high write-protects the guarded registers
// Notes:   o_clk_gate/o_clk_src are per-clock routing results
module gcrb_route_bank
	import gcrb_pkg::*;
#(
	parameter int NCLK = 64,
	parameter int NGEN = 9
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_n,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [11:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic [3:0]        i_pstrb,
	input  wire logic              i_prot,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output logic      [NCLK-1:0]   o_clk_gate,
	output logic      [4*NCLK-1:0] o_clk_src,
	output logic      [NGEN-1:0]   o_gen_on
);
	gcrb_sync_if sy ();

	gcrb_sync_timer u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.sy        (sy)
	);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [NCLK-1:0] gate_ff;
	logic [NCLK-1:0] gate_vis_ff;
	logic [NCLK-1:0] freeze_ff;
	logic [3:0]      sel_ff [NCLK];
	logic [31:0]     setup_ff [NGEN];
	logic [31:0]     ratio_ff [NGEN];
	logic [NGEN-1:0] gen_lock;
	logic [5:0]      idx_ff;
	logic [3:0]      gidx_s_ff;
	logic [3:0]      gidx_r_ff;
	logic            soft_reset_bit_ff;
	logic            gate_pend_ff;
	logic [5:0]      gate_idx_ff;
	logic [31:0]     prdata_ff;
	logic            pready_ff;
	logic            pslverr_ff;
	logic [NCLK-1:0] gate_ff_q;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b])
				r[8*b+:8] = wd[8*b+:8];
		end
		return r;
	endfunction : lane_merge

	wire access  = i_psel && i_penable;
	wire hit_w0  = (i_paddr == ADDR_CTRL_WORD);
	wire hit_set = (i_paddr == ADDR_GEN_SETUP);
	wire hit_rat = (i_paddr == ADDR_GEN_RATIO);
	wire mapped  = hit_w0 || hit_set || hit_rat;
	// stall while sync pending
	// route writes wait too: a second gate change would steal the pend slot
	wire needs_sync = i_pwrite && ((hit_w0 && (i_pstrb[0] || i_pstrb[3]))
		|| hit_set || hit_rat);
	wire stall   = needs_sync && (sy.busy || gate_pend_ff);
	wire fire    = access && !pready_ff && !stall;
	wire wr      = fire && i_pwrite && mapped;
	wire wr_ok   = wr && !i_prot;

	wire wr_ctrl  = wr_ok && hit_w0 && i_pstrb[0];
	wire wr_idx   = wr_ok && hit_w0 && i_pstrb[2];
	wire wr_route = wr_ok && hit_w0 && i_pstrb[3];
	wire [5:0] w_idx = i_pstrb[2] ? i_pwdata[IDX_LO+:6] : idx_ff;
	wire [3:0] w_sel = i_pwdata[SEL_LO+:4];
	wire start_rst = wr_ctrl && i_pwdata[SOFT_RESET_POS] && !soft_reset_bit_ff;

	wire [3:0] w_gidx_s = i_pstrb[0] ? i_pwdata[3:0] : gidx_s_ff;
	wire [3:0] w_gidx_r = i_pstrb[0] ? i_pwdata[3:0] : gidx_r_ff;
	wire wr_set = wr_ok && hit_set && (w_gidx_s <= GEN_MAX);
	wire wr_rat = wr_ok && hit_rat && (w_gidx_r <= GEN_MAX);
	wire [31:0] set_new = lane_merge(setup_ff[w_gidx_s], i_pwdata,
		i_pstrb) & SETUP_MASK;
	wire [31:0] rat_new = lane_merge(ratio_ff[w_gidx_r], i_pwdata,
		i_pstrb) & RATIO_MASK;

	always_comb begin
		gen_lock = '0;
		for (int c = 0; c < NCLK; c++) begin
			if (freeze_ff[c] && sel_ff[c] != 4'h0 && sel_ff[c] <= GEN_MAX)
				gen_lock[sel_ff[c]] = 1'b1;
		end
	end

	wire rst_done = soft_reset_bit_ff && sy.done;
	wire start_sync = start_rst || (wr_set && !gen_lock[w_gidx_s])
		|| (wr_rat && !gen_lock[w_gidx_r]);

	wire gate_start = wr_route && !freeze_ff[w_idx]
		&& (i_pwdata[GATE_POS] != gate_vis_ff[w_idx]);
	assign sy.start = start_sync || (gate_start && !start_sync);

	// ------------------------------------------------------------
	// per-clock routing storage
	// ------------------------------------------------------------
	genvar gc;
	generate
		for (gc = 0; gc < NCLK; gc++) begin : g_clk
			wire this_w = wr_route && (w_idx == gc[5:0]) && !freeze_ff[gc];
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					gate_ff[gc]     <= 1'b0;
					gate_vis_ff[gc] <= 1'b0;
					freeze_ff[gc]   <= 1'b0;
					sel_ff[gc]      <= 4'h0;
				end else if (rst_done && !freeze_ff[gc]) begin
					gate_ff[gc]     <= 1'b0;
					gate_vis_ff[gc] <= 1'b0;
					sel_ff[gc]      <= 4'h0;
				end else begin
					if (this_w) begin
						gate_ff[gc]   <= i_pwdata[GATE_POS];
						freeze_ff[gc] <= i_pwdata[FREEZE_POS];
						sel_ff[gc]    <= w_sel;
					end
					if (gate_pend_ff && sy.done && gate_idx_ff == gc[5:0])
						gate_vis_ff[gc] <= gate_ff[gc];
				end
			end
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					gate_ff_q[gc]        <= 1'b0;
					o_clk_src[4*gc+:4]   <= 4'h0;
				end else begin
					gate_ff_q[gc]        <= gate_vis_ff[gc]
						&& (sel_ff[gc] <= GEN_MAX);
					o_clk_src[4*gc+:4]   <= sel_ff[gc];
				end
			end
		end
	endgenerate
	assign o_clk_gate = gate_ff_q;

	// ------------------------------------------------------------
	// generators
	// ------------------------------------------------------------
	genvar gg;
	generate
		for (gg = 0; gg < NGEN; gg++) begin : g_gen
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					setup_ff[gg] <= SETUP_RST;
					ratio_ff[gg] <= RATIO_RST;
					o_gen_on[gg] <= 1'b0;
				end else begin
					if (rst_done && !gen_lock[gg]) begin
						setup_ff[gg] <= SETUP_RST;
						ratio_ff[gg] <= RATIO_RST;
					end else begin
						if (wr_set && w_gidx_s == gg[3:0] && !gen_lock[gg]
							&& !sy.busy)
							setup_ff[gg] <= set_new | {28'h0, gg[3:0]};
						if (wr_rat && w_gidx_r == gg[3:0] && !gen_lock[gg]
							&& !sy.busy)
							ratio_ff[gg] <= rat_new | {28'h0, gg[3:0]};
					end
					o_gen_on[gg] <= setup_ff[gg][16];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// control, indexes, soft reset, bus answer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			soft_reset_bit_ff     <= 1'b0;
			idx_ff       <= 6'h00;
			gidx_s_ff    <= 4'h0;
			gidx_r_ff    <= 4'h0;
			gate_pend_ff <= 1'b0;
			gate_idx_ff  <= 6'h00;
		end else begin
			if (start_rst)
				soft_reset_bit_ff <= 1'b1;
			else if (rst_done)
				soft_reset_bit_ff <= 1'b0;
			if (rst_done)
				idx_ff <= 6'h00;
			else if (wr_idx)
				idx_ff <= w_idx;
			if (wr_ok && hit_set && i_pstrb[0])
				gidx_s_ff <= w_gidx_s;
			if (wr_ok && hit_rat && i_pstrb[0])
				gidx_r_ff <= w_gidx_r;
			if (gate_start && !start_sync) begin
				gate_pend_ff <= 1'b1;
				gate_idx_ff  <= w_idx;
			end else if (sy.done) begin
				gate_pend_ff <= 1'b0;
			end
		end
	end

	wire [31:0] rd_w0 = {freeze_ff[idx_ff], gate_vis_ff[idx_ff], 2'b00,
		sel_ff[idx_ff], 2'b00, idx_ff, sy.busy, 14'h0000, soft_reset_bit_ff};
	wire [31:0] rd_set = (gidx_s_ff <= GEN_MAX) ?
		((setup_ff[gidx_s_ff] & SETUP_MASK & 32'hfffffff0)
		| {28'h0, gidx_s_ff}) : {28'h0, gidx_s_ff};
	wire [31:0] rd_rat = (gidx_r_ff <= GEN_MAX) ?
		((ratio_ff[gidx_r_ff] & RATIO_MASK & 32'hfffffff0)
		| {28'h0, gidx_r_ff}) : {28'h0, gidx_r_ff};
	wire [31:0] rd_mux = hit_w0 ? rd_w0 : hit_set ? rd_set :
		hit_rat ? rd_rat : 32'h00000000;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= fire;
			pslverr_ff <= fire && (!mapped || (i_pwrite && i_prot));
			if (fire && !i_pwrite)
				prdata_ff <= rd_mux;
		end
	end
	assign o_pready  = pready_ff;
	assign o_prdata  = prdata_ff;
	assign o_pslverr = pslverr_ff;
endmodule : gcrb_route_bank

// >>> gcrb_route_bank_chk.sv
// Purpose: port assertions of the clock register bank
// Assumes: the master holds a request until pready
// Notes:   bound to the bank below
`timescale 1ns/1ns
module gcrb_route_bank_chk (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic        i_prot,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	sequence setup_s;
		i_psel && !i_penable ##1 i_psel && i_penable;
	endsequence
	sequence rd0_s;
		o_pready && !i_pwrite && i_paddr == 12'h000;
	endsequence
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("pready held");
	ready_held_a: assert property (o_pready |-> i_psel && i_penable)
		else $error("pready outside access");
	err_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("pslverr alone");
	// stall after a busy flag is bounded, never endless
	answer_bound_a: assert property (setup_s |-> ##[0:20] o_pready)
		else $error("no answer");
	data_hold_a: assert property (
		$changed(o_prdata) |-> o_pready && !i_pwrite)
		else $error("read data moved");
	// ----------------------------------------
	// register contents
	// ----------------------------------------
	prot_err_a: assert property (
		o_pready && i_pwrite && i_prot |-> o_pslverr)
		else $error("guarded write taken");
	resv_zero_a: assert property (rd0_s |-> o_prdata[14:1] == 14'h0
		&& o_prdata[23:22] == 2'h0 && o_prdata[29:28] == 2'h0)
		else $error("reserved bit set");
	reset_busy_a: assert property (
		rd0_s |-> !o_prdata[0] || o_prdata[15])
		else $error("reset without busy");
	unmapped_err_a: assert property (
		o_pready && i_paddr > 12'h008 |-> o_pslverr)
		else $error("unmapped without error");
endmodule : gcrb_route_bank_chk

bind gcrb_route_bank gcrb_route_bank_chk gcrb_route_bank_chk_inst (
	.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .i_prot, .o_prdata, .o_pready, .o_pslverr);

// >>> gcrb_apb_host.sv
// Purpose: software side of the bank, an apb master
// Assumes: one transfer at a time, called just after an edge
// Notes:   write data inverted when idle so stale data never matches
`timescale 1ns/1ns
module gcrb_apb_host (
	input  wire logic        i_clk_sys,
	input  wire logic        i_pready,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pslverr,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [11:0] o_paddr,
	output logic      [31:0] o_pwdata,
	output logic      [3:0]  o_pstrb
);
	initial begin
		{o_psel, o_penable, o_pwrite} = 3'h0;
		{o_paddr, o_pwdata, o_pstrb} = 48'h0;
	end
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge i_clk_sys);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		o_pstrb <= s;
		@(posedge i_clk_sys);
		o_penable <= 1'b1;
		do @(posedge i_clk_sys); while (i_pready !== 1'b1);
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_pwdata <= ~d;
	endtask : xfer
endmodule : gcrb_apb_host

// >>> tb_top.sv
// Purpose: self-checking bench of the clock register bank
// Assumes: software side played by gcrb_apb_host
// Notes:   clocks 60-63 are kept out of the random draw for corners
`timescale 1ns/1ns
module tb_top;
	logic         i_clk_sys, i_rst_n, i_prot, er;
	logic         i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
	logic [11:0]  i_paddr;
	logic [31:0]  i_pwdata, o_prdata, rd;
	logic [3:0]   i_pstrb;
	logic [63:0]  gate, eg;
	logic [255:0] src;
	logic [8:0]   gen_on;
	logic [15:0]  lf;
	logic [5:0]   ix;
	int           fail_count, n_checks, i;

	gcrb_route_bank gcrb_route_bank_inst (
		.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .i_pstrb, .i_prot, .o_prdata,
		.o_pready, .o_pslverr, .o_clk_gate(gate),
		.o_clk_src(src), .o_gen_on(gen_on));
	gcrb_apb_host gcrb_apb_host_inst (
		.i_clk_sys, .i_pready(o_pready), .i_prdata(o_prdata),
		.i_pslverr(o_pslverr), .o_psel(i_psel),
		.o_penable(i_penable), .o_pwrite(i_pwrite),
		.o_paddr(i_paddr), .o_pwdata(i_pwdata), .o_pstrb(i_pstrb));

	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task t(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		gcrb_apb_host_inst.xfer(w, a, d, s, rd, er);
	endtask : t
	task final_report;
		if (fail_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nx
	function automatic logic [31:0] rv(input logic [5:0] x,
		input logic [3:0] g, input logic en, input logic fz);
		return {fz, en, 2'b00, g, 2'b00, x, 16'h0000};
	endfunction : rv

	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	// a hung handshake would otherwise stall the run for ever
	initial begin
		repeat (6000) @(posedge i_clk_sys);
		fail_count++;
		final_report;
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		i_rst_n = 1'b0;
		i_prot = 1'b0;
		fail_count = 0;
		n_checks = 0;
		lf = 16'hce27;
		eg = '0;
		repeat (8) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		t(0, 12'h000, 32'h0, 4'h0);
		chk("rst_word", 64'h0, 64'(rd));
		for (i = 0; i < 16; i++) begin
			lf = nx(lf);
			ix = 6'(lf % 16'd60);
			t(1, 12'h000, rv(ix, 4'(i), 1'b1, 1'b0), 4'hc);
			t(1, 12'h004, 32'h00010000 | i, 4'hf);
			chk("stall_err", 64'h0, 64'(er));
			repeat (10) @(posedge i_clk_sys);
			eg[ix] = i < 9;
			t(1, 12'h000, {10'h0, ix, 16'h0}, 4'h4);
			t(0, 12'h000, 32'h0, 4'h0);
			chk("route", 64'({4'(i), 2'h0, ix}), 64'(rd[27:16]));
			chk("busy", 64'h0, 64'(rd[15]));
			chk("gate", eg, gate);
			chk("src", 64'(i), 64'(src[ix*4 +: 4]));
			if (i < 9)
				chk("gen_on", 64'h1, 64'(gen_on[i]));
		end
		t(1, 12'h000, rv(6'd60, 4'h2, 1'b1, 1'b0), 4'hc);
		t(0, 12'h000, 32'h0, 4'h0);
		chk("old_gate", 64'h0, 64'(rd[30]));
		chk("busy_on", 64'h1, 64'(rd[15]));
		t(1, 12'h000, rv(6'd62, 4'h3, 1'b1, 1'b1), 4'hc);
		t(1, 12'h000, rv(6'd63, 4'h0, 1'b1, 1'b1), 4'hc);
		t(1, 12'h000, rv(6'd62, 4'h5, 1'b0, 1'b0), 4'hc);
		t(1, 12'h004, 32'h3, 4'hf);
		t(1, 12'h004, 32'h0, 4'hf);
		repeat (10) @(posedge i_clk_sys);
		eg[63:60] = 4'hd;
		chk("frozen", eg, gate);
		chk("gen3", 64'h1, 64'(gen_on[3]));
		chk("gen0", 64'h0, 64'(gen_on[0]));
		i_prot <= 1'b1;
		t(1, 12'h000, rv(6'd61, 4'h1, 1'b1, 1'b0), 4'hc);
		chk("prot", 64'h1, 64'(er));
		i_prot <= 1'b0;
		t(0, 12'h00c, 32'h0, 4'h0);
		chk("unmapped", 64'h1, {rd, 31'h0, er});
		t(1, 12'h000, 32'h0, 4'h1);
		repeat (10) @(posedge i_clk_sys);
		chk("zero_wr", eg, gate);
		t(1, 12'h000, 32'h1, 4'h1);
		t(0, 12'h000, 32'h0, 4'h0);
		chk("soft_reset_bit_on", 64'h8001, 64'(rd[15:0]));
		repeat (12) @(posedge i_clk_sys);
		t(0, 12'h000, 32'h0, 4'h0);
		chk("soft_reset_bit_off", 64'h0, 64'(rd[15:0]));
		chk("keep", 64'hc000000000000000, gate);
		chk("gen_keep", 64'h8, 64'(gen_on));
		t(1, 12'h004, 32'h3, 4'h1);
		t(0, 12'h004, 32'h0, 4'h0);
		chk("gen_setup", 64'h00010003, 64'(rd));
		t(1, 12'h004, 32'h1, 4'h1);
		t(0, 12'h004, 32'h0, 4'h0);
		chk("gen1_rst", 64'h1, 64'(rd));
		final_report;
	end
endmodule : tb_top
